// file: include/swm_defines.vh
// constants for the shadow window mirror: register offsets, field layouts,
// reset values and window size codes; included by bare name, no logic here
`ifndef SWM_DEFINES_VH
`define SWM_DEFINES_VH

// register port offsets (byte addresses, one aligned word each)
`define SWM_ADDR_W 8
`define SWM_OFF_WIN_LAST 8'h3c
`define SWM_OFF_CTRL 8'h40
`define SWM_OFF_STATUS 8'h44

// window count and split between the two directions
`define SWM_NUM_WIN 8
`define SWM_FIRST_M2C 4

// card-side start register layout
`define SWM_CARD_TOP 11'h184
`define SWM_CARD_FIELD_W 8
// memory-side start register layout
`define SWM_MEM_TOP 1'b1
`define SWM_MEM_FIELD_W 18
// low address bits that always read as zero
`define SWM_LOW_ZERO 13'h0000

// size field codes
`define SWM_SIZE_OFF 2'h0
`define SWM_SIZE_8K 2'h1
`define SWM_SIZE_16K 2'h2
`define SWM_SIZE_32K 2'h3
// in-window offset masks per size (word addresses)
`define SWM_MASK_8K 32'h00001fff
`define SWM_MASK_16K 32'h00003fff
`define SWM_MASK_32K 32'h00007fff

// reset values
`define SWM_CTRL_RST 16'h0000
`define SWM_FIELD_RST 18'h00000

// status register bits
`define SWM_STAT_PEND 0
`define SWM_STAT_DROP 1
`define SWM_STAT_DIR 2
`define SWM_STAT_WIN_LO 4

`endif

// file: rtl/swm_shadow_window_mirror.v
// shadow window mirror: watches completed processor reads on the local bus
// and replays each one that hits an enabled window, unless a stalled write is pending, as a write to the mirror
// region (card-to-memory windows 0..3, memory-to-card windows 4..7).
// assumes: cpu_rd_* is a one-cycle pulse per completed read, word addressed,
// synchronous to mclk; the write sink may stall through mir_ready.
//
// Functional notes
// - windows 0-3 copy card-window reads into same-sized DDR region, same offset.
// - windows 4-7 write DDR-window read data to matching card target location.
// - card-side start bits 31:21 are read-only and return 0x184.
// - card-side bits 20:13 writable; bits 12:0 always read zero.
// - memory-side start bit 31 is read-only and returns one.
// - memory-side bits 30:13 writable; bits 12:0 always read zero.
// - windows are aligned to their size; hits decoded on that basis.
// - size code 00 off, 01 8k words, 10 16k words, 11 32k words.
// - control register packs one 2-bit size per window, ascending order.
// - control register resets to zero; bits 31:16 unused.
// - writable start fields reset to zero and read back last write.
// - all windows share the start layouts of windows 0 and 4.
`timescale 1ns/1ps
`default_nettype none
`include "swm_defines.vh"

module swm_shadow_window_mirror (
	input wire mclk,
	input wire reset_n,
	input wire ce,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire cpu_rd_valid,
	input wire [31:0] cpu_rd_addr,
	input wire [31:0] cpu_rd_data,
	output wire mir_valid,
	input wire mir_ready,
	output reg [31:0] mir_addr,
	output reg [31:0] mir_data,
	output reg mir_to_card
);

	localparam ST_IDLE = 1'b0;
	localparam ST_PEND = 1'b1;

	// in-window offset mask for a size code
	function [31:0] size_mask;
		input [1:0] code;
		begin
			case (code)
				`SWM_SIZE_8K: size_mask = `SWM_MASK_8K;
				`SWM_SIZE_16K: size_mask = `SWM_MASK_16K;
				`SWM_SIZE_32K: size_mask = `SWM_MASK_32K;
				default: size_mask = 32'h00000000;
			endcase
		end
	endfunction

	// full start address as seen in the processor map
	function [31:0] full_addr;
		input is_card;
		input [17:0] field;
		begin
			if (is_card) begin
				full_addr = {`SWM_CARD_TOP, field[7:0], `SWM_LOW_ZERO};
			end else begin
				full_addr = {`SWM_MEM_TOP, field, `SWM_LOW_ZERO};
			end
		end
	endfunction

	// writable width of a start field: card fields keep only 8 bits
	function [17:0] field_keep;
		input is_card;
		input [17:0] value;
		begin
			if (is_card) begin
				field_keep = {10'h000, value[7:0]};
			end else begin
				field_keep = value;
			end
		end
	endfunction

	reg [17:0] src_field [0:7];
	reg [17:0] tgt_field [0:7];
	reg [15:0] ctrl;
	reg state;
	reg dropped;
	reg [2:0] last_win;
	reg [2:0] next_win;
	reg next_hit;
	reg [31:0] next_rdata;
	integer i;
	// separate loop index for the reset loop keeps one driver per variable
	integer j;

	wire [7:0] hit;
	wire [255:0] tgt_flat;
	wire win_access;
	wire [2:0] win_idx;
	wire win_is_tgt;
	wire win_src_card;
	wire win_tgt_card;
	wire take;

	assign win_access = (reg_addr <= `SWM_OFF_WIN_LAST) && (reg_addr[1:0] == 2'h0);
	assign win_idx = reg_addr[5:3];
	assign win_is_tgt = reg_addr[2];
	// source is card space for the low four windows, memory for the rest
	assign win_src_card = (win_idx < `SWM_FIRST_M2C);
	assign win_tgt_card = ~win_src_card;

	// per-window hit decode and target address
	genvar g;
	generate
		for (g = 0; g < `SWM_NUM_WIN; g = g + 1) begin : gen_win
			wire card_src;
			wire [1:0] size_code;
			wire [31:0] msk;
			wire [31:0] src_full;
			wire [31:0] tgt_full;
			assign card_src = (g < `SWM_FIRST_M2C);
			assign size_code = ctrl[2 * g + 1:2 * g];
			assign msk = size_mask(size_code);
			assign src_full = full_addr(card_src, src_field[g]);
			assign tgt_full = full_addr(~card_src, tgt_field[g]);
			// base compared above the size only: start assumed size-aligned
			assign hit[g] = (size_code != `SWM_SIZE_OFF) &&
				((cpu_rd_addr & ~msk) == (src_full & ~msk));
			// same relative offset inside the target region
			assign tgt_flat[g * 32 +: 32] = (tgt_full & ~msk) | (cpu_rd_addr & msk);
		end
	endgenerate

	// overlapping windows: the lowest numbered one wins
	always @* begin
		next_win = 3'h0;
		next_hit = 1'b0;
		for (i = `SWM_NUM_WIN - 1; i >= 0; i = i - 1) begin
			if (hit[i]) begin
				next_win = i[2:0];
				next_hit = 1'b1;
			end
		end
	end

	assign mir_valid = (state == ST_PEND);
	// a new hit is taken when idle or when the pending one leaves now
	assign take = ce && cpu_rd_valid && next_hit && (!mir_valid || mir_ready);

	// register read mux
	always @* begin
		next_rdata = 32'h00000000;
		if (win_access) begin
			if (win_is_tgt) begin
				next_rdata = full_addr(win_tgt_card, tgt_field[win_idx]);
			end else begin
				next_rdata = full_addr(win_src_card, src_field[win_idx]);
			end
		end else if (reg_addr == `SWM_OFF_CTRL) begin
			next_rdata = {16'h0000, ctrl};
		end else if (reg_addr == `SWM_OFF_STATUS) begin
			next_rdata[`SWM_STAT_PEND] = mir_valid;
			next_rdata[`SWM_STAT_DROP] = dropped;
			next_rdata[`SWM_STAT_DIR] = mir_to_card;
			next_rdata[`SWM_STAT_WIN_LO +: 3] = last_win;
		end
	end

	// register file
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= `SWM_CTRL_RST;
			for (j = 0; j < `SWM_NUM_WIN; j = j + 1) begin
				src_field[j] <= `SWM_FIELD_RST;
				tgt_field[j] <= `SWM_FIELD_RST;
			end
			reg_rdata <= 32'h00000000;
		end else if (ce) begin
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end else begin
				reg_rdata <= 32'h00000000;
			end
			if (reg_wr && win_access) begin
				if (win_is_tgt) begin
					tgt_field[win_idx] <= field_keep(win_tgt_card, reg_wdata[30:13]);
				end else begin
					src_field[win_idx] <= field_keep(win_src_card, reg_wdata[30:13]);
				end
			end
			if (reg_wr && (reg_addr == `SWM_OFF_CTRL)) begin
				ctrl <= reg_wdata[15:0];
			end
		end
	end

	// mirror write holding stage; the processor read path is only observed
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			mir_addr <= 32'h00000000;
			mir_data <= 32'h00000000;
			mir_to_card <= 1'b0;
			last_win <= 3'h0;
			dropped <= 1'b0;
		end else if (ce) begin
			case (state)
				ST_IDLE: begin
					if (take) begin
						state <= ST_PEND;
					end
				end
				ST_PEND: begin
					if (mir_ready && !take) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
			if (take) begin
				mir_addr <= tgt_flat[next_win * 32 +: 32];
				mir_data <= cpu_rd_data;
				mir_to_card <= (next_win >= `SWM_FIRST_M2C);
				last_win <= next_win;
			end
			// one-deep stage: a hit meeting a stalled sink is lost and flagged;
			// set beats a same-cycle clear
			if (cpu_rd_valid && next_hit && mir_valid && !mir_ready) begin
				dropped <= 1'b1;
			end else if (reg_wr && (reg_addr == `SWM_OFF_STATUS) && reg_wdata[`SWM_STAT_DROP]) begin
				dropped <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// file: verif/swm_properties.sv
// checker for the shadow window mirror, bound to its ports
// assumes ce is held high by the bench
`timescale 1ns/1ps
`default_nettype none
module swm_properties (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic cpu_rd_valid,
	input wire logic [31:0] cpu_rd_addr,
	input wire logic [31:0] cpu_rd_data,
	input wire logic mir_valid,
	input wire logic mir_ready,
	input wire logic [31:0] mir_addr,
	input wire logic [31:0] mir_data,
	input wire logic mir_to_card
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not idle");
	ctrl_high_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h40 |-> reg_rdata[31:16] == 16'h0)
		else $error("control upper half not zero");
	card_layout_a: assert property ($past(reg_rd) && $past(reg_addr) < 8'h40 && $past(reg_addr[1:0]) == 2'h0
		&& $past(reg_addr[5]) == $past(reg_addr[2])
		|-> reg_rdata[31:21] == 11'h184 && reg_rdata[12:0] == 13'h0)
		else $error("card start layout wrong");
	mem_layout_a: assert property ($past(reg_rd) && $past(reg_addr) < 8'h40 && $past(reg_addr[1:0]) == 2'h0
		&& $past(reg_addr[5]) != $past(reg_addr[2])
		|-> reg_rdata[31] && reg_rdata[12:0] == 13'h0)
		else $error("memory start layout wrong");
	mir_hold_a: assert property (mir_valid && !mir_ready |=> mir_valid && $stable(mir_addr) && $stable(mir_data))
		else $error("mirror write not held");
	mir_cause_a: assert property ($rose(mir_valid) |-> $past(cpu_rd_valid))
		else $error("mirror write without read");
	mir_data_a: assert property ($rose(mir_valid) |-> mir_data == $past(cpu_rd_data))
		else $error("mirror data differs from read");
	mir_offs_a: assert property ($rose(mir_valid) |-> ((mir_addr ^ $past(cpu_rd_addr)) & 32'h1fff) == 32'h0)
		else $error("mirror offset lost");
	mir_side_a: assert property ($rose(mir_valid) |-> (mir_to_card ? mir_addr[31:21] == 11'h184 : mir_addr[31]))
		else $error("mirror target outside region");
endmodule
bind swm_shadow_window_mirror swm_properties chk (.*);
`default_nettype wire

// file: verif/swm_cpu_model.sv
// processor model: one completed read pulse per call
// assumes the caller leaves a clock edge between calls
`timescale 1ns/1ps
`default_nettype none
module swm_cpu_model (
	input wire logic mclk,
	output logic cpu_rd_valid,
	output logic [31:0] cpu_rd_addr,
	output logic [31:0] cpu_rd_data
);
	initial begin
		cpu_rd_valid = 1'h0;
		cpu_rd_addr = 32'h0;
		cpu_rd_data = 32'h0;
	end
	task rd(input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk);
		cpu_rd_valid <= 1'h1;
		cpu_rd_addr <= a;
		cpu_rd_data <= d;
		@(posedge mclk);
		// released bus shows junk so a stale value cannot pass
		cpu_rd_valid <= 1'h0;
		cpu_rd_addr <= ~a;
		cpu_rd_data <= ~d;
	endtask
endmodule
`default_nettype wire

// file: verif/swm_shadow_window_mirror_tb_top.sv
// bench for the shadow window mirror: registers, window hits and misses
// assumes ce held high; the mirror sink stalls at random
`timescale 1ns/1ps
`default_nettype none
module swm_shadow_window_mirror_tb_top;
	logic mclk = 1'h0, reset_n = 1'h0, ce = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, mir_ready = 1'h1, rd_d = 1'h0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, s = 32'h2c06, wv [16], sa, ta, o, m, d;
	logic [1:0] c;
	wire [31:0] reg_rdata, cpu_rd_addr, cpu_rd_data, mir_addr, mir_data;
	wire cpu_rd_valid, mir_valid, mir_to_card;
	logic [31:0] rq [$];
	logic [64:0] mq [$];
	int n_errors = 0, n_compared = 0, n, k;
	always #25 mclk = ~mclk;
	swm_shadow_window_mirror DUT (.*);
	swm_cpu_model cpu (.*);
	function logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function logic [31:0] lay(input logic [7:0] a, input logic [31:0] w);
		return (a[5] == a[2]) ? {11'h184, w[20:13], 13'h0} : {1'h1, w[30:13], 13'h0};
	endfunction
	task cmp(input logic [64:0] g, input logic [64:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task report_and_stop;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		@(posedge mclk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'h0;
	endtask
	task drain;
		for (k = 0; k < 60 && (k < 3 || mir_valid !== 1'h0); k++) begin
			@(posedge mclk);
			mir_ready <= s[0];
			s = xs(s);
			#1;
		end
		if (k == 60) begin
			n_errors++;
			report_and_stop();
		end
		// a lost mirror write leaves its note behind
		cmp(65'(mq.size()), 65'h0);
	endtask
	always @(posedge mclk) begin
		if (rd_d)
			cmp({33'h0, reg_rdata}, rq.pop_front());
		if (mir_valid === 1'h1 && mir_ready)
			cmp({mir_to_card, mir_addr, mir_data}, mq.size() ? mq.pop_front() : 65'hx);
		rd_d <= reg_rd;
	end
	initial begin
		repeat (6) @(posedge mclk);
		reset_n <= 1'h1;
		for (k = 0; k <= 'h44; k += 4)
			rd(k[7:0], k < 'h40 ? lay(k[7:0], 32'h0) : 32'h0);
		rd(8'h80, 32'h0);
		$display("reset values done");
		for (n = 0; n < 16; n++) begin
			s = xs(s);
			wv[n] = s & 32'hffff9fff;
			wr({n[5:0], 2'h0}, wv[n]);
			rd({n[5:0], 2'h0}, lay({n[5:0], 2'h0}, wv[n]));
		end
		s = xs(s);
		wr(8'h40, s);
		rd(8'h40, {16'h0, s[15:0]});
		$display("register access done");
		for (n = 0; n < 8; n++) begin
			c = 2'(n % 3 + 1);
			m = (32'h2000 << (c - 2'h1)) - 32'h1;
			wr(8'h40, 32'(c) << (2 * n));
			sa = lay({n[4:0], 3'h0}, wv[2 * n]);
			ta = lay({n[4:0], 3'h4}, wv[2 * n + 1]);
			s = xs(s);
			o = s & m;
			d = xs(s);
			mq.push_back({n > 3, ta | o, d});
			cpu.rd(sa | o, d);
			drain();
			cpu.rd(sa ^ (m + 32'h1), d);
			drain();
		end
		wr(8'h40, 32'h0);
		cpu.rd(sa, d);
		drain();
		$display("window mirroring done");
		report_and_stop();
	end
endmodule
`default_nettype wire
